// ===== src/pidmac_add.sv
`timescale 1ns/100ps
// 36-bit adder reporting wrap for signed or unsigned operands
module pidmac_add (
    input  wire logic        is_signed,
    input  wire logic [35:0] a,
    input  wire logic [35:0] b,
    output logic      [35:0] sum,
    output logic             wrap
);
    logic [36:0] full;
    // carry out for unsigned, sign mismatch for signed
    always_comb begin
        full = {1'b0, a} + {1'b0, b};
        sum  = full[35:0];
        if (is_signed) begin
            wrap = (a[35] == b[35]) && (full[35] != a[35]);
        end else begin
            wrap = full[36];
        end
    end
endmodule : pidmac_add

// ===== src/pidmac_mul.sv
`timescale 1ns/100ps
// registered 18x18 signed product, one cycle latency
module pidmac_mul (
    input  wire logic               sys_clk,
    input  wire logic signed [17:0] op_a,
    input  wire logic signed [17:0] op_b,
    output logic signed      [35:0] product
);
    // register keeps the multiplier off the accumulate path
    always_ff @(posedge sys_clk) begin
        product <= op_a * op_b;
    end
endmodule : pidmac_mul

// ===== src/pidmac_pkg.sv
package pidmac_pkg;
    // register word addresses (byte offsets, one aligned word each)
    localparam logic [7:0] ADDR_CONFIG      = 8'h00;
    localparam logic [7:0] ADDR_FB_HIGH     = 8'h04;
    localparam logic [7:0] ADDR_FB_LOW      = 8'h08;
    localparam logic [7:0] ADDR_TARGET_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_TARGET_LOW  = 8'h10;
    localparam logic [7:0] ADDR_GAIN_A_HIGH = 8'h14;
    localparam logic [7:0] ADDR_GAIN_A_LOW  = 8'h18;
    localparam logic [7:0] ADDR_GAIN_B_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_GAIN_B_LOW  = 8'h20;
    localparam logic [7:0] ADDR_GAIN_C_HIGH = 8'h24;
    localparam logic [7:0] ADDR_GAIN_C_LOW  = 8'h28;
    localparam logic [7:0] ADDR_RES_UPPER   = 8'h2C;
    localparam logic [7:0] ADDR_RES_HH      = 8'h30;
    localparam logic [7:0] ADDR_RES_HL      = 8'h34;
    localparam logic [7:0] ADDR_RES_LH      = 8'h38;
    localparam logic [7:0] ADDR_RES_LL      = 8'h3C;
    localparam logic [7:0] ADDR_FLAGS       = 8'h40;
    // config fields
    localparam int CFG_EN_BIT   = 7;
    localparam int CFG_BUSY_BIT = 6;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h87;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    // flags register fields
    localparam int FLG_DONE_BIT = 0;
    localparam int FLG_OVF_BIT  = 1;
    // operation select codes
    localparam logic [2:0] MODE_U_SET = 3'h0;
    localparam logic [2:0] MODE_U_ACC = 3'h1;
    localparam logic [2:0] MODE_S_SET = 3'h2;
    localparam logic [2:0] MODE_S_ACC = 3'h3;
    localparam logic [2:0] MODE_PID   = 3'h5;
    // result width and calculation length in cycles
    localparam int RES_W = 36;
    localparam int CALC_CYCLES = 2;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : pidmac_pkg

// ===== src/pidmac_top.sv
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module pidmac_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import pidmac_pkg::*;

    logic [7:0]  config_reg;
    logic [15:0] feedback_reg;
    logic [15:0] target_reg;
    logic [15:0] gain_a_reg;
    logic [15:0] gain_b_reg;
    logic [15:0] gain_c_reg;
    logic [35:0] result_reg;
    logic [16:0] err1_reg;
    logic [16:0] err2_reg;
    logic        busy_reg;
    logic [1:0]  step_reg;
    logic        done_flag_reg;
    logic        overflow_flag_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    // decode of a pending write: both halves captured
    logic        wr_fire;
    logic        wr_lane0;
    logic [7:0]  wr_byte;
    assign wr_fire  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && w_strb_reg[0];
    assign wr_byte  = w_data_reg[7:0];
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= ADDR_FLAGS) && (a[1:0] == 2'b00);
    endfunction : addr_known
    // axi write address and data taken in either order
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // ready is registered: one item held at a time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
            s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
        end
    end

    // write response one cycle after both halves held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration: enable and operation select only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            config_reg <= CFG_RESET;
        end else if (wr_lane0 && aw_addr_reg == ADDR_CONFIG) begin
            config_reg <= wr_byte & CFG_WRITE_MASK;
        end
    end

    // feedback has no reset: keeps contents across resets
    always_ff @(posedge sys_clk) begin
        if (wr_lane0 && aw_addr_reg == ADDR_FB_HIGH) begin
            feedback_reg[15:8] <= wr_byte;
        end
        if (wr_lane0 && aw_addr_reg == ADDR_FB_LOW) begin
            feedback_reg[7:0] <= wr_byte;
        end
    end

    // target and gain byte pairs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            target_reg <= 16'h0000;
            gain_a_reg <= 16'h0000;
            gain_b_reg <= 16'h0000;
            gain_c_reg <= 16'h0000;
        end else if (wr_lane0) begin
            unique case (aw_addr_reg)
                ADDR_TARGET_HIGH: target_reg[15:8] <= wr_byte;
                ADDR_TARGET_LOW:  target_reg[7:0]  <= wr_byte;
                ADDR_GAIN_A_HIGH: gain_a_reg[15:8] <= wr_byte;
                ADDR_GAIN_A_LOW:  gain_a_reg[7:0]  <= wr_byte;
                ADDR_GAIN_B_HIGH: gain_b_reg[15:8] <= wr_byte;
                ADDR_GAIN_B_LOW:  gain_b_reg[7:0]  <= wr_byte;
                ADDR_GAIN_C_HIGH: gain_c_reg[15:8] <= wr_byte;
                ADDR_GAIN_C_LOW:  gain_c_reg[7:0]  <= wr_byte;
                default: ;
            endcase
        end
    end
    // calculation start: low feedback byte written while enabled
    logic start;
    assign start = wr_lane0 && aw_addr_reg == ADDR_FB_LOW && config_reg[CFG_EN_BIT] && !busy_reg;
    // operand selection per step, sign-extended to 18 bits in signed and pid modes, zero-extended in unsigned modes
    logic        op_signed;
    logic        op_accum;
    logic        op_pid;
    logic [16:0] err_now;
    logic signed [17:0] mul_a;
    logic signed [17:0] mul_b;
    logic signed [35:0] product;
    assign op_pid    = config_reg[2:0] == MODE_PID;
    assign op_signed = op_pid || config_reg[1];
    assign op_accum  = op_pid || config_reg[0];
    // error is target minus feedback, 17 bits to hold its sign
    assign err_now   = 17'({target_reg[15], target_reg} - {feedback_reg[15], feedback_reg});
    // every branch sets both operands, so no defaults are needed
    always_comb begin
        if (op_pid) begin
            unique case (step_reg)
                2'd0: begin
                    mul_a = {err_now[16], err_now};
                    mul_b = {{2{gain_a_reg[15]}}, gain_a_reg};
                end
                2'd1: begin
                    mul_a = {err1_reg[16], err1_reg};
                    mul_b = {{2{gain_b_reg[15]}}, gain_b_reg};
                end
                default: begin
                    mul_a = {err2_reg[16], err2_reg};
                    mul_b = {{2{gain_c_reg[15]}}, gain_c_reg};
                end
            endcase
        end else if (op_signed) begin
            // both sides sign-extended to the full 18 bits, else negatives turn positive
            mul_a = {{2{target_reg[15]}}, target_reg} + {{2{feedback_reg[15]}}, feedback_reg};
            mul_b = {{2{gain_a_reg[15]}}, gain_a_reg};
        end else begin
            mul_a = 18'({1'b0, target_reg} + {1'b0, feedback_reg});
            mul_b = {2'b00, gain_a_reg};
        end
    end
    pidmac_mul u_mul (
        .sys_clk (sys_clk),
        .op_a    (mul_a),
        .op_b    (mul_b),
        .product (product)
    );
    // accumulate base: zero on the first term of a non-accumulating run
    logic        first_term_reg;
    logic [35:0] acc_base;
    logic [35:0] acc_sum;
    logic        acc_wrap;
    assign acc_base = (first_term_reg && !op_accum) ? 36'h0_0000_0000 : result_reg;
    pidmac_add u_add (
        .is_signed (op_signed),
        .a         (acc_base),
        .b         (product),
        .sum       (acc_sum),
        .wrap      (acc_wrap)
    );
    // sequencer: a term is issued each cycle and folded in the cycle after,
    // since the multiplier register puts one cycle between operands and product
    localparam logic [1:0] END_STEP = 2'(CALC_CYCLES + 1);
    logic mul_valid_reg;
    logic calc_end;
    assign calc_end = busy_reg && mul_valid_reg && (!op_pid || step_reg == END_STEP);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_reg       <= 1'b0;
            step_reg       <= 2'd0;
            mul_valid_reg  <= 1'b0;
            first_term_reg <= 1'b0;
        end else if (start) begin
            busy_reg       <= 1'b1;
            step_reg       <= 2'd0;
            mul_valid_reg  <= 1'b0;
            first_term_reg <= 1'b1;
        end else if (calc_end) begin
            busy_reg       <= 1'b0;
            mul_valid_reg  <= 1'b0;
            first_term_reg <= 1'b0;
        end else if (busy_reg) begin
            mul_valid_reg  <= 1'b1;
            first_term_reg <= first_term_reg && !mul_valid_reg;
            step_reg       <= step_reg + 2'd1;
        end
    end
    // result: folded by hardware, or written bytewise by software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_reg <= 36'h0_0000_0000;
        end else if (busy_reg && mul_valid_reg) begin
            result_reg <= acc_sum;
        end else if (wr_lane0) begin
            unique case (aw_addr_reg)
                ADDR_RES_UPPER: result_reg[35:32] <= wr_byte[3:0];
                ADDR_RES_HH:    result_reg[31:24] <= wr_byte;
                ADDR_RES_HL:    result_reg[23:16] <= wr_byte;
                ADDR_RES_LH:    result_reg[15:8]  <= wr_byte;
                ADDR_RES_LL:    result_reg[7:0]   <= wr_byte;
                default: ;
            endcase
        end
    end
    // error history shifts once per completed pid run
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            err1_reg <= 17'h0_0000;
            err2_reg <= 17'h0_0000;
        end else if (calc_end && op_pid) begin
            err2_reg <= err1_reg;
            err1_reg <= err_now;
        end
    end
    // done and overflow flags; hardware set wins over software clear
    logic flag_wr;
    assign flag_wr  = wr_lane0 && aw_addr_reg == ADDR_FLAGS;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_flag_reg     <= 1'b0;
            overflow_flag_reg <= 1'b0;
        end else begin
            if (calc_end) begin
                done_flag_reg <= 1'b1;
            end else if (flag_wr && !wr_byte[FLG_DONE_BIT]) begin
                done_flag_reg <= 1'b0;
            end
            if (busy_reg && mul_valid_reg && acc_wrap) begin
                overflow_flag_reg <= 1'b1;
            end else if (flag_wr && !wr_byte[FLG_OVF_BIT]) begin
                overflow_flag_reg <= 1'b0;
            end
        end
    end
    // read channel: one cycle from address taken to data
    logic [7:0] rd_byte;
    always_comb begin
        unique case (s_axi_araddr)
            ADDR_CONFIG:      rd_byte = {config_reg[CFG_EN_BIT], busy_reg, 3'b000, config_reg[2:0]};
            ADDR_FB_HIGH:     rd_byte = feedback_reg[15:8];
            ADDR_FB_LOW:      rd_byte = feedback_reg[7:0];
            ADDR_TARGET_HIGH: rd_byte = target_reg[15:8];
            ADDR_TARGET_LOW:  rd_byte = target_reg[7:0];
            ADDR_GAIN_A_HIGH: rd_byte = gain_a_reg[15:8];
            ADDR_GAIN_A_LOW:  rd_byte = gain_a_reg[7:0];
            ADDR_GAIN_B_HIGH: rd_byte = gain_b_reg[15:8];
            ADDR_GAIN_B_LOW:  rd_byte = gain_b_reg[7:0];
            ADDR_GAIN_C_HIGH: rd_byte = gain_c_reg[15:8];
            ADDR_GAIN_C_LOW:  rd_byte = gain_c_reg[7:0];
            ADDR_RES_UPPER:   rd_byte = {4'h0, result_reg[35:32]};
            ADDR_RES_HH:      rd_byte = result_reg[31:24];
            ADDR_RES_HL:      rd_byte = result_reg[23:16];
            ADDR_RES_LH:      rd_byte = result_reg[15:8];
            ADDR_RES_LL:      rd_byte = result_reg[7:0];
            ADDR_FLAGS:       rd_byte = {6'h00, overflow_flag_reg, done_flag_reg};
            default:          rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= addr_known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : pidmac_top

// ===== test/pid_multiply_accumulate_bench.sv
`timescale 1ns/100ps
module pid_multiply_accumulate_bench;
    import pidmac_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [35:0] v;
    int          error_cnt = 0;
    int          check_count = 0;

    pidmac_top dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // 40 ns period
    always #20 sys_clk = ~sys_clk;

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one write; bready is up from the start, so the answer is taken when seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no cycle count assumed: only the watchdog ends a wait
        forever begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk("bresp", 36'(er), 36'(s_axi_bresp));
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [35:0] r, input logic [1:0] er = AXI_OKAY);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 36'h0;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                r = 36'(s_axi_rdata);
                chk("rresp", 36'(er), 36'(s_axi_rresp));
                break;
            end
        end
    endtask : rd

    task automatic rc(input string nm, input logic [7:0] a, input logic [35:0] e);
        logic [35:0] r;
        rd(a, r);
        chk(nm, e, r);
    endtask : rc

    // five result bytes, top first
    task automatic rdres(output logic [35:0] r);
        logic [35:0] b;
        r = 36'h0;
        for (int i = 0; i < 5; i++) begin
            rd(ADDR_RES_UPPER + 8'(4 * i), b);
            r = {r[27:0], b[7:0]};
        end
    endtask : rdres

    // whole calculation: operands, start, poll busy, then result and flags
    task automatic calc(input logic [2:0] m, input logic [15:0] fb, tg, ga, input logic [35:0] e, input logic ov);
        logic [35:0] r;
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_CONFIG, {5'h10, m});
        wr(ADDR_TARGET_HIGH, tg[15:8]);
        wr(ADDR_TARGET_LOW, tg[7:0]);
        wr(ADDR_GAIN_A_HIGH, ga[15:8]);
        wr(ADDR_GAIN_A_LOW, ga[7:0]);
        wr(ADDR_FB_HIGH, fb[15:8]);
        rc("no start on high byte", ADDR_FLAGS, 36'h0);
        wr(ADDR_FB_LOW, fb[7:0]);
        rd(ADDR_CONFIG, r);
        if (m == MODE_PID) chk("busy while running", 36'h1, 36'(r[6]));
        // nothing else is written until busy has dropped
        for (int n = 0; n < 20 && r[6] !== 1'b0; n++) rd(ADDR_CONFIG, r);
        chk("busy clears", 36'h0, 36'(r[6]));
        rdres(r);
        chk("result", e, r);
        rd(ADDR_FLAGS, r);
        chk("overflow flag", 36'(ov), 36'(r[1]));
        if (!ov) chk("done flag", 36'h1, 36'(r[0]));
    endtask : calc

    task automatic pulse_rst;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse_rst

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int a = 0; a <= 8'h40; a += 4) if (a != 4 && a != 8) rc("reset value", 8'(a), 36'h0);
        wr(ADDR_CONFIG, 8'hFD);
        rc("config fields", ADDR_CONFIG, 36'h85);
        for (int a = 8'h0C; a <= 8'h20; a += 4) wr(8'(a), 8'(a) ^ 8'hA5);
        for (int a = 8'h0C; a <= 8'h20; a += 4) rc("rw", 8'(a), 36'(8'(a) ^ 8'hA5));
        // disabled unit must not start on the low byte
        wr(ADDR_CONFIG, 8'h00);
        wr(ADDR_FB_HIGH, 8'h5A);
        wr(ADDR_FB_LOW, 8'h3C);
        rc("feedback high", ADDR_FB_HIGH, 36'h5A);
        rc("feedback low", ADDR_FB_LOW, 36'h3C);
        rc("disabled no done", ADDR_FLAGS, 36'h0);
        pulse_rst();
        rc("feedback kept", ADDR_FB_HIGH, 36'h5A);
        rc("target cleared", ADDR_TARGET_HIGH, 36'h0);
        // operand sum carries into bit 16, then signed negative results
        calc(MODE_U_SET, 16'hFFFF, 16'h0001, 16'h0002, 36'h2_0000, 1'b0);
        calc(MODE_U_ACC, 16'hFFFF, 16'h0001, 16'h0002, 36'h4_0000, 1'b0);
        calc(MODE_S_SET, 16'hFFFE, 16'h0001, 16'h0003, 36'hF_FFFF_FFFD, 1'b0);
        calc(MODE_S_ACC, 16'hFFFE, 16'h0001, 16'h0003, 36'hF_FFFF_FFFA, 1'b0);
        // saturate by software, then wrap past the top
        for (int i = 0; i < 5; i++) wr(ADDR_RES_UPPER + 8'(4 * i), 8'hFF);
        rc("top nibble only", ADDR_RES_UPPER, 36'hF);
        rdres(v);
        chk("saturated", 36'hF_FFFF_FFFF, v);
        calc(MODE_U_ACC, 16'h0001, 16'h0000, 16'h0001, 36'h0, 1'b1);
        wr(ADDR_FLAGS, 8'h02);
        rc("overflow kept", ADDR_FLAGS, 36'h2);
        wr(ADDR_FLAGS, 8'h01);
        rc("overflow cleared", ADDR_FLAGS, 36'h0);
        // fresh history: error 6 then 3, previous error weighted by second gain
        pulse_rst();
        calc(MODE_PID, 16'h0004, 16'h000A, 16'h0002, 36'hC, 1'b0);
        wr(ADDR_GAIN_B_LOW, 8'h01);
        calc(MODE_PID, 16'h0007, 16'h000A, 16'h0002, 36'h18, 1'b0);
        wr(8'h44, 8'h11, AXI_SLVERR);
        rd(8'h44, v, AXI_SLVERR);
        chk("unmapped data", 36'h0, v);
        rd(8'h02, v, AXI_SLVERR);
        end_sim();
    end
endmodule : pid_multiply_accumulate_bench

// ===== test/pidmac_top_properties.sv
`timescale 1ns/100ps
// watches the register bus of the unit from outside
module pidmac_top_checker
    import pidmac_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    logic [7:0] rd_addr_reg;
    logic       bad_rd;

    // read address kept until its data leaves, so data checks know the source
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_addr_reg <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end
    assign bad_rd = (rd_addr_reg > ADDR_FLAGS) || (rd_addr_reg[1:0] != 2'h0);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after request");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    cfg_gap_a: assert property (s_axi_rvalid && rd_addr_reg == ADDR_CONFIG |-> s_axi_rdata[5:3] == 3'h0)
        else $error("config unused bits not zero");
    res_nibble_a: assert property (s_axi_rvalid && rd_addr_reg == ADDR_RES_UPPER |-> s_axi_rdata[7:4] == 4'h0)
        else $error("result top nibble not zero");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above byte not zero");
    bad_addr_a: assert property (s_axi_rvalid && bad_rd |-> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    good_addr_a: assert property (s_axi_rvalid && !bad_rd |-> s_axi_rresp == AXI_OKAY)
        else $error("mapped read refused");
endmodule : pidmac_top_checker

bind pidmac_top pidmac_top_checker chk_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
